//--- emb_pkg.sv
// Package for the external memory bus interface: constants, kinds and states
package emb_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 8;
    localparam int PHASE_NS = 32;
    // Clocks per bus phase, at least one
    localparam int PHASE_CYC = (PHASE_NS / CLK_PERIOD_NS) < 1 ? 1 : (PHASE_NS / CLK_PERIOD_NS);
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] PHASE_LAST = CNT_W'(PHASE_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;

    // ****************************************
    // Address space
    // ****************************************
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] INT_CODE_LIMIT = 16'h1000;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;

    // ****************************************
    // Reset, idle and active values of pins and data
    // ****************************************
    localparam logic STROBE_OFF = 1'h1;
    localparam logic STROBE_ON = 1'h0;
    localparam logic LATCH_OPEN = 1'h1;
    localparam logic LATCH_SHUT = 1'h0;
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] BYTE_RELEASED = 8'hFF;
    localparam logic [DATA_W-1:0] BYTE_DRIVEN = 8'h00;

    // ****************************************
    // Access kinds and bus states
    // ****************************************
    typedef enum logic [1:0] {
        EMB_FETCH,
        EMB_TABLE_READ,
        EMB_DATA_READ,
        EMB_DATA_WRITE
    } emb_kind_t;

    typedef enum logic [1:0] {
        EMB_IDLE,
        EMB_ADDR,
        EMB_LATCH,
        EMB_STROBE
    } emb_state_t;

endpackage : emb_pkg

//--- emb_bus.sv
// External memory bus interface: multiplexed address/data port, strobes and internal/external code select
`timescale 1ns/1ps
// Summary of operation
// - Select input low sends every code fetch to external memory over the bus.
// - Select high and address in on-chip code: no fetch appears on the bus.
// - Program store strobe pulses for external fetches and external table reads.
// - No program store strobe at all for on-chip code fetches.
// - Address latch strobe falls to latch the low byte; latch holds it after.
// - Low address byte and data byte share the low port, time multiplexed.
// - High address port carries the upper address during bus accesses.
// - One port bit is the data write strobe, another the data read strobe.
// - Separate 64 KB code and data spaces with a 16-bit address.
// - Low port is open-drain as general I/O; pull-ups give the high level.
module emb_bus (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic external_access_select_n,
    input wire logic req_valid,
    output logic req_ready,
    input wire emb_pkg::emb_kind_t req_kind,
    input wire logic [emb_pkg::ADDR_W-1:0] req_addr,
    input wire logic [emb_pkg::DATA_W-1:0] req_wdata,
    output logic resp_valid,
    output logic resp_internal,
    output logic [emb_pkg::DATA_W-1:0] resp_rdata,
    output logic code_internal,
    input wire logic [emb_pkg::DATA_W-1:0] low_port_gpio_out,
    input wire logic [emb_pkg::DATA_W-1:0] high_port_gpio_out,
    input wire logic write_pin_gpio_out,
    input wire logic read_pin_gpio_out,
    input wire logic [emb_pkg::DATA_W-1:0] low_byte_bus_port_in,
    output logic [emb_pkg::DATA_W-1:0] low_byte_bus_port_out,
    output logic [emb_pkg::DATA_W-1:0] low_byte_bus_port_oe_n,
    output logic [emb_pkg::DATA_W-1:0] high_address_port,
    output logic address_latch_strobe,
    output logic program_store_strobe_n,
    output logic write_strobe_n,
    output logic read_strobe_n
);

    // ****************************************
    // Decoding
    // ****************************************
    // Code access served from on-chip memory, so the bus stays quiet
    function automatic logic emb_is_internal(
        input emb_pkg::emb_kind_t kind,
        input logic [emb_pkg::ADDR_W-1:0] addr,
        input logic ea_n
    );
        logic code;
        code = (kind == emb_pkg::EMB_FETCH) || (kind == emb_pkg::EMB_TABLE_READ);
        return code && ea_n && (addr < emb_pkg::INT_CODE_LIMIT);
    endfunction : emb_is_internal

    function automatic logic emb_is_code(input emb_pkg::emb_kind_t kind);
        return (kind == emb_pkg::EMB_FETCH) || (kind == emb_pkg::EMB_TABLE_READ);
    endfunction : emb_is_code

    // ****************************************
    // State
    // ****************************************
    emb_pkg::emb_state_t st;
    emb_pkg::emb_state_t next_st;
    logic [emb_pkg::CNT_W-1:0] cnt;
    logic [emb_pkg::CNT_W-1:0] next_cnt;
    emb_pkg::emb_kind_t kind;
    emb_pkg::emb_kind_t next_kind;
    logic [emb_pkg::ADDR_W-1:0] addr;
    logic [emb_pkg::ADDR_W-1:0] next_addr;
    logic [emb_pkg::DATA_W-1:0] wdata;
    logic [emb_pkg::DATA_W-1:0] next_wdata;
    logic next_resp_valid;
    logic next_resp_internal;
    logic [emb_pkg::DATA_W-1:0] next_resp_rdata;
    logic [emb_pkg::DATA_W-1:0] next_p0_out;
    logic [emb_pkg::DATA_W-1:0] next_p0_oe_n;
    logic [emb_pkg::DATA_W-1:0] next_p2;
    logic next_ale;
    logic next_pss_n;
    logic next_wr_n;
    logic next_rd_n;
    logic tick;
    logic accept;

    assign req_ready = (st == emb_pkg::EMB_IDLE);
    assign accept = req_valid && req_ready;
    assign tick = (cnt == emb_pkg::PHASE_LAST);
    assign code_internal = emb_is_internal(req_kind, req_addr, external_access_select_n);

    // ****************************************
    // Next state and pin values
    // ****************************************
    always_comb
    begin
        next_st = st;
        next_cnt = cnt;
        next_kind = kind;
        next_addr = addr;
        next_wdata = wdata;
        next_resp_valid = 1'h0;
        next_resp_internal = 1'h0;
        next_resp_rdata = resp_rdata;
        // Phase divider runs only during a bus access
        if (st != emb_pkg::EMB_IDLE)
        begin
            next_cnt = tick ? emb_pkg::CNT_RESET : cnt + 4'h1;
        end
        case (st)
            emb_pkg::EMB_IDLE:
            begin
                next_cnt = emb_pkg::CNT_RESET;
                if (accept)
                begin
                    next_kind = req_kind;
                    next_addr = req_addr;
                    next_wdata = req_wdata;
                    if (emb_is_internal(req_kind, req_addr, external_access_select_n))
                    begin
                        // On-chip code: answered at once, bus untouched
                        next_resp_valid = 1'h1;
                        next_resp_internal = 1'h1;
                    end
                    else
                    begin
                        next_st = emb_pkg::EMB_ADDR;
                    end
                end
            end
            emb_pkg::EMB_ADDR:
            begin
                if (tick)
                begin
                    next_st = emb_pkg::EMB_LATCH;
                end
            end
            emb_pkg::EMB_LATCH:
            begin
                if (tick)
                begin
                    next_st = emb_pkg::EMB_STROBE;
                end
            end
            emb_pkg::EMB_STROBE:
            begin
                if (tick)
                begin
                    next_st = emb_pkg::EMB_IDLE;
                    next_resp_valid = 1'h1;
                    if (kind != emb_pkg::EMB_DATA_WRITE)
                    begin
                        next_resp_rdata = low_byte_bus_port_in;
                    end
                end
            end
            default:
            begin
                next_st = emb_pkg::EMB_IDLE;
            end
        endcase

        // Pins follow the state being entered, so they change on phase edges
        next_ale = emb_pkg::LATCH_SHUT;
        next_pss_n = emb_pkg::STROBE_OFF;
        next_wr_n = write_pin_gpio_out;
        next_rd_n = read_pin_gpio_out;
        next_p2 = high_port_gpio_out;
        next_p0_out = emb_pkg::BYTE_ZERO;
        next_p0_oe_n = low_port_gpio_out;
        case (next_st)
            emb_pkg::EMB_IDLE:
            begin
                next_p0_oe_n = low_port_gpio_out;
            end
            emb_pkg::EMB_ADDR:
            begin
                next_ale = emb_pkg::LATCH_OPEN;
                next_p2 = next_addr[emb_pkg::ADDR_W-1:emb_pkg::DATA_W];
                next_p0_out = next_addr[emb_pkg::DATA_W-1:0];
                next_p0_oe_n = emb_pkg::BYTE_DRIVEN;
                next_wr_n = emb_pkg::STROBE_OFF;
                next_rd_n = emb_pkg::STROBE_OFF;
            end
            emb_pkg::EMB_LATCH:
            begin
                // Address held while the latch strobe falls
                next_p2 = addr[emb_pkg::ADDR_W-1:emb_pkg::DATA_W];
                next_p0_out = addr[emb_pkg::DATA_W-1:0];
                next_p0_oe_n = emb_pkg::BYTE_DRIVEN;
                next_wr_n = emb_pkg::STROBE_OFF;
                next_rd_n = emb_pkg::STROBE_OFF;
            end
            emb_pkg::EMB_STROBE:
            begin
                next_p2 = addr[emb_pkg::ADDR_W-1:emb_pkg::DATA_W];
                next_wr_n = emb_pkg::STROBE_OFF;
                next_rd_n = emb_pkg::STROBE_OFF;
                next_p0_oe_n = emb_pkg::BYTE_RELEASED;
                if (emb_is_code(kind))
                begin
                    next_pss_n = emb_pkg::STROBE_ON;
                end
                else if (kind == emb_pkg::EMB_DATA_READ)
                begin
                    next_rd_n = emb_pkg::STROBE_ON;
                end
                else
                begin
                    next_wr_n = emb_pkg::STROBE_ON;
                    next_p0_out = wdata;
                    next_p0_oe_n = emb_pkg::BYTE_DRIVEN;
                end
            end
            default:
            begin
                next_p0_oe_n = low_port_gpio_out;
            end
        endcase
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            st <= emb_pkg::EMB_IDLE;
            cnt <= emb_pkg::CNT_RESET;
            kind <= emb_pkg::EMB_FETCH;
            addr <= emb_pkg::ADDR_RESET;
            wdata <= emb_pkg::BYTE_ZERO;
            resp_valid <= 1'h0;
            resp_internal <= 1'h0;
            resp_rdata <= emb_pkg::BYTE_ZERO;
            low_byte_bus_port_out <= emb_pkg::BYTE_ZERO;
            low_byte_bus_port_oe_n <= emb_pkg::BYTE_RELEASED;
            high_address_port <= emb_pkg::BYTE_RELEASED;
            address_latch_strobe <= emb_pkg::LATCH_SHUT;
            program_store_strobe_n <= emb_pkg::STROBE_OFF;
            write_strobe_n <= emb_pkg::STROBE_OFF;
            read_strobe_n <= emb_pkg::STROBE_OFF;
        end
        else
        begin
            st <= next_st;
            cnt <= next_cnt;
            kind <= next_kind;
            addr <= next_addr;
            wdata <= next_wdata;
            resp_valid <= next_resp_valid;
            resp_internal <= next_resp_internal;
            resp_rdata <= next_resp_rdata;
            low_byte_bus_port_out <= next_p0_out;
            low_byte_bus_port_oe_n <= next_p0_oe_n;
            high_address_port <= next_p2;
            address_latch_strobe <= next_ale;
            program_store_strobe_n <= next_pss_n;
            write_strobe_n <= next_wr_n;
            read_strobe_n <= next_rd_n;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    localparam int RESP_LAT = 1 + 3 * emb_pkg::PHASE_CYC;
    localparam int PSS_LAT = RESP_LAT - 1;

    default clocking emb_cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    AST_EA_LOW_EXTERNAL: assert property (
        (accept && !external_access_select_n) |=> address_latch_strobe && !resp_valid)
        else $error("fetch with select low did not start a bus cycle");

    AST_INTERNAL_QUIET: assert property (
        (accept && code_internal) |=> resp_valid && resp_internal && !address_latch_strobe && req_ready)
        else $error("on-chip code access disturbed the bus");

    AST_PSS_FOR_CODE: assert property (
        (accept && !code_internal && emb_is_code(req_kind)) |-> ##PSS_LAT !program_store_strobe_n)
        else $error("program store strobe missing for external code access");

    AST_PSS_ONLY_EXTERNAL: assert property (
        !program_store_strobe_n |-> (st == emb_pkg::EMB_STROBE) && emb_is_code(kind) && read_strobe_n)
        else $error("program store strobe outside an external code access");

    AST_ALE_FALL_HOLDS: assert property (
        $fell(address_latch_strobe) |-> (st == emb_pkg::EMB_LATCH) && (low_byte_bus_port_oe_n == emb_pkg::BYTE_DRIVEN)
            && (low_byte_bus_port_out == $past(low_byte_bus_port_out)))
        else $error("low byte not stable at latch strobe fall");

    AST_LOW_BYTE_MUX: assert property (
        (st == emb_pkg::EMB_ADDR) |-> (low_byte_bus_port_out == addr[emb_pkg::DATA_W-1:0]) && address_latch_strobe)
        else $error("low address byte not on the low port");

    AST_HIGH_BYTE: assert property (
        (st != emb_pkg::EMB_IDLE) |-> (high_address_port == addr[emb_pkg::ADDR_W-1:emb_pkg::DATA_W]))
        else $error("high address byte not on the high port");

    AST_WRITE_STROBE: assert property (
        ((st == emb_pkg::EMB_STROBE) && (kind == emb_pkg::EMB_DATA_WRITE)) |-> !write_strobe_n && read_strobe_n
            && (low_byte_bus_port_out == wdata) && program_store_strobe_n)
        else $error("write strobe or write data wrong");

    AST_READ_STROBE: assert property (
        ((st == emb_pkg::EMB_STROBE) && (kind == emb_pkg::EMB_DATA_READ)) |-> !read_strobe_n && write_strobe_n
            && (low_byte_bus_port_oe_n == emb_pkg::BYTE_RELEASED))
        else $error("read strobe wrong or low port still driven");

    AST_RESP_LATENCY: assert property (
        (accept && !code_internal) |-> ##RESP_LAT resp_valid && !resp_internal)
        else $error("external access answer not on time");

    AST_OPEN_DRAIN_IDLE: assert property (
        ((st == emb_pkg::EMB_IDLE) && ($past(st) == emb_pkg::EMB_IDLE)) |->
            (low_byte_bus_port_out == emb_pkg::BYTE_ZERO) && (low_byte_bus_port_oe_n == $past(low_port_gpio_out)))
        else $error("low port not open-drain while idle");

    AST_STROBES_IDLE: assert property (
        ((st == emb_pkg::EMB_IDLE) && ($past(st) == emb_pkg::EMB_IDLE)) |->
            program_store_strobe_n && !address_latch_strobe)
        else $error("strobe active while idle");

endmodule : emb_bus

//--- emb_far_mem.sv
// Partner model: external code memory, data memory and address latch on the multiplexed bus
`timescale 1ns/1ps
module emb_far_mem (
    input wire logic mclk,
    input wire logic slow,
    input wire logic [7:0] pad,
    input wire logic [7:0] high_address_port,
    input wire logic address_latch_strobe,
    input wire logic program_store_strobe_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    output logic drv_en,
    output logic [7:0] drv,
    output logic [15:0] latched_addr
);
    logic [7:0] low_latch = 8'h00;
    logic [7:0] ram [0:65535];
    bit ram_ok [0:65535];
    logic [7:0] word;
    int unsigned low_cnt = 0;

    // ****************************************
    // Address latch
    // ****************************************
    // Latch keeps the low byte after the port turns to data
    always @(negedge address_latch_strobe) low_latch = pad;
    assign latched_addr = {high_address_port, low_latch};

    // ****************************************
    // Memories
    // ****************************************
    always @(posedge mclk)
    begin
        if (!program_store_strobe_n || !read_strobe_n)
            low_cnt <= low_cnt + 1;
        else
            low_cnt <= 0;
        if (!write_strobe_n)
        begin
            ram[latched_addr] = pad;
            ram_ok[latched_addr] = 1'b1;
        end
    end

    always @*
    begin
        if (!program_store_strobe_n)
            word = latched_addr[7:0] ^ latched_addr[15:8] ^ 8'hA5;
        else if (ram_ok[latched_addr])
            word = ram[latched_addr];
        else
            word = 8'h00;
        // A slow memory shows the inverted byte for two strobed cycles before its byte settles
        drv_en = !program_store_strobe_n || !read_strobe_n;
        drv = (slow && low_cnt < 2) ? ~word : word;
    end
endmodule : emb_far_mem

//--- tb.sv
// Testbench for the external memory bus interface
`timescale 1ns/1ps
`define CHK(act, exp) begin n_checks++; if ((act) !== (exp)) begin n_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, act, exp); end end
module tb;
    logic mclk = 1'h0;
    logic resetn = 1'h0;
    logic sel_n = 1'h1;
    logic req_valid = 1'h0;
    emb_pkg::emb_kind_t req_kind = emb_pkg::EMB_FETCH;
    logic [15:0] req_addr = 16'h0000;
    logic [7:0] req_wdata = 8'h00;
    logic [7:0] lo_gpio = 8'hFF;
    logic [7:0] hi_gpio = 8'hFF;
    logic wr_gpio = 1'h1;
    logic rd_gpio = 1'h1;
    logic slow = 1'h0;
    logic req_ready, resp_valid, resp_internal, code_internal, ale, ps_n, wr_n, rd_n, drv_en;
    logic [7:0] resp_rdata, port_out, port_oe_n, high_port, pad, drv;
    logic [15:0] latched_addr;
    int n_errors = 0;
    int n_checks = 0;

    // Open-drain low port with pull-ups: released bits read high
    assign pad = (~port_oe_n & port_out) | (port_oe_n & (drv_en ? drv : 8'hFF));

    emb_bus u_emb_bus (.mclk(mclk), .resetn(resetn), .external_access_select_n(sel_n),
        .req_valid(req_valid), .req_ready(req_ready), .req_kind(req_kind), .req_addr(req_addr),
        .req_wdata(req_wdata), .resp_valid(resp_valid), .resp_internal(resp_internal),
        .resp_rdata(resp_rdata), .code_internal(code_internal), .low_port_gpio_out(lo_gpio),
        .high_port_gpio_out(hi_gpio), .write_pin_gpio_out(wr_gpio), .read_pin_gpio_out(rd_gpio),
        .low_byte_bus_port_in(pad), .low_byte_bus_port_out(port_out), .low_byte_bus_port_oe_n(port_oe_n),
        .high_address_port(high_port), .address_latch_strobe(ale), .program_store_strobe_n(ps_n),
        .write_strobe_n(wr_n), .read_strobe_n(rd_n));

    emb_far_mem u_emb_far_mem (.mclk(mclk), .slow(slow), .pad(pad), .high_address_port(high_port),
        .address_latch_strobe(ale), .program_store_strobe_n(ps_n), .read_strobe_n(rd_n),
        .write_strobe_n(wr_n), .drv_en(drv_en), .drv(drv), .latched_addr(latched_addr));

    initial
    begin
        forever #4 mclk = ~mclk;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    function automatic logic [7:0] rom_exp(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'hA5;
    endfunction : rom_exp

    task automatic acc(input emb_pkg::emb_kind_t k, input logic [15:0] a, input logic [7:0] wd,
        input logic s_n, input logic [7:0] exp_d);
        logic code;
        logic intl;
        int pc;
        int cyc;
        int n_ale = 0;
        int n_ps = 0;
        int n_rd = 0;
        int n_wr = 0;
        code = (k == emb_pkg::EMB_FETCH) || (k == emb_pkg::EMB_TABLE_READ);
        intl = code && s_n && (a < emb_pkg::INT_CODE_LIMIT);
        pc = intl ? 0 : emb_pkg::PHASE_CYC;
        req_kind = k;
        req_addr = a;
        req_wdata = wd;
        sel_n = s_n;
        req_valid = 1'h1;
        #1;
        `CHK(code_internal, intl)
        @(negedge mclk);
        req_valid = 1'h0;
        cyc = 1;
        while (resp_valid !== 1'h1 && cyc <= 20)
        begin
            if (ale === 1'h1)
            begin
                n_ale++;
                `CHK(pad, a[7:0])
            end
            `CHK(high_port, a[15:8])
            n_ps += (ps_n === 1'h0);
            n_rd += (rd_n === 1'h0);
            n_wr += (wr_n === 1'h0);
            if (wr_n === 1'h0)
                `CHK(pad, wd)
            // High port returns to its general value with the answer, so the address is checked while strobed
            if (ps_n === 1'h0 || rd_n === 1'h0 || wr_n === 1'h0)
                `CHK(latched_addr, a)
            @(negedge mclk);
            cyc++;
        end
        `CHK(cyc, intl ? 1 : 1 + 3 * emb_pkg::PHASE_CYC)
        `CHK(resp_internal, intl)
        `CHK(n_ale, pc)
        `CHK(n_ps, code ? pc : 0)
        `CHK(n_rd, (k == emb_pkg::EMB_DATA_READ) ? pc : 0)
        `CHK(n_wr, (k == emb_pkg::EMB_DATA_WRITE) ? pc : 0)
        if (!intl && k != emb_pkg::EMB_DATA_WRITE)
            `CHK(resp_rdata, exp_d)
    endtask : acc

    task automatic wrap_up();
        if (n_errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        repeat (2) @(negedge mclk);
        `CHK({ale, ps_n, wr_n, rd_n, req_ready}, 5'h0F)
        `CHK(port_oe_n, 8'hFF)
        resetn = 1'h1;
    endtask : t_reset

    task automatic t_gpio();
        lo_gpio = 8'h5A;
        hi_gpio = 8'hC3;
        repeat (2) @(negedge mclk);
        `CHK(port_oe_n, 8'h5A)
        `CHK(pad, 8'h5A)
        `CHK(high_port, 8'hC3)
        // Far memory drives the port while the read pin is low, so the port is checked before
        wr_gpio = 1'h0;
        rd_gpio = 1'h0;
        repeat (2) @(negedge mclk);
        `CHK({wr_n, rd_n}, 2'h0)
        wr_gpio = 1'h1;
        rd_gpio = 1'h1;
        @(negedge mclk);
    endtask : t_gpio

    task automatic t_fetch_select();
        acc(emb_pkg::EMB_FETCH, 16'h0123, 8'h00, 1'h0, rom_exp(16'h0123));
        acc(emb_pkg::EMB_FETCH, 16'h0FFF, 8'h00, 1'h1, 8'h00);
        acc(emb_pkg::EMB_FETCH, 16'h1000, 8'h00, 1'h1, rom_exp(16'h1000));
    endtask : t_fetch_select

    task automatic t_table_read();
        acc(emb_pkg::EMB_TABLE_READ, 16'h0800, 8'h00, 1'h1, 8'h00);
        acc(emb_pkg::EMB_TABLE_READ, 16'hFEDC, 8'h00, 1'h1, rom_exp(16'hFEDC));
    endtask : t_table_read

    task automatic t_data_spaces();
        acc(emb_pkg::EMB_DATA_WRITE, 16'h0123, 8'h3C, 1'h1, 8'h00);
        acc(emb_pkg::EMB_DATA_WRITE, 16'hFFFF, 8'hC3, 1'h0, 8'h00);
        acc(emb_pkg::EMB_DATA_READ, 16'h0123, 8'h00, 1'h1, 8'h3C);
        acc(emb_pkg::EMB_FETCH, 16'h0123, 8'h00, 1'h0, rom_exp(16'h0123));
    endtask : t_data_spaces

    task automatic t_slow_memory();
        slow = 1'h1;
        acc(emb_pkg::EMB_DATA_READ, 16'hFFFF, 8'h00, 1'h1, 8'hC3);
        acc(emb_pkg::EMB_FETCH, 16'hABCD, 8'h00, 1'h1, rom_exp(16'hABCD));
        slow = 1'h0;
    endtask : t_slow_memory

    initial
    begin
        t_reset();
        t_gpio();
        t_fetch_select();
        t_table_read();
        t_data_spaces();
        t_slow_memory();
        wrap_up();
    end

    // Hang guard, far beyond the about 130 cycles the scenarios need
    initial
    begin
        #(3000 * emb_pkg::CLK_PERIOD_NS);
        n_errors++;
        wrap_up();
    end
endmodule : tb
